// File: common/scse_pkg.sv
// register map, field positions, reset values and counts of the serial control block
package scse_pkg;
	// register indices on the plain register port
	localparam logic [3:0] SCSE_A_CTRL = 4'h0;
	localparam logic [3:0] SCSE_A_MODE = 4'h1;
	localparam logic [3:0] SCSE_A_STAT = 4'h2;
	localparam logic [3:0] SCSE_A_TXD = 4'h3;
	localparam logic [3:0] SCSE_A_SCMODE = 4'h4;
	localparam logic [3:0] SCSE_A_RXD = 4'h5;
	localparam logic [3:0] SCSE_A_IRQ_STAT = 4'h6;
	localparam logic [3:0] SCSE_A_IRQ_MASK = 4'h7;
	localparam logic [3:0] SCSE_A_BAUD = 4'h8;
	// serial_control_reg fields
	localparam int SCSE_B_TX_IRQ_ON = 7;
	localparam int SCSE_B_RX_IRQ_ON = 6;
	localparam int SCSE_B_TX_ON = 5;
	localparam int SCSE_B_RX_ON = 4;
	localparam int SCSE_B_CLOCK_SELECT_HI = 1;
	localparam int SCSE_B_CLOCK_SELECT_LO = 0;
	// serial_mode_reg and smart_card_mode_reg fields
	localparam int SCSE_M_SYNC = 0;
	localparam int SCSE_M_PAR_ON = 1;
	localparam int SCSE_M_PAR_ODD = 2;
	localparam int SCSE_M_SMART_CARD_SELECT = 0;
	// status flags sit in bits 7..3 of serial_status_reg
	localparam int SCSE_STAT_LSB = 3;
	localparam int SCSE_F_TX_BUFFER_EMPTY = 4;
	localparam int SCSE_F_RX_BUFFER_FULL = 3;
	localparam int SCSE_F_OVERRUN_ERROR = 2;
	localparam int SCSE_F_FRAMING_ERROR = 1;
	localparam int SCSE_F_PARITY_ERROR = 0;
	// sticky event bits
	localparam int SCSE_E_TX = 0;
	localparam int SCSE_E_RX = 1;
	localparam int SCSE_E_ERR = 2;
	// reset values
	localparam logic [7:0] SCSE_CTRL_RST = 8'h00;
	localparam logic [7:0] SCSE_BAUD_RST = 8'h0f;
	localparam logic [4:0] SCSE_FLAGS_RST = 5'h10;
	// clock select codes
	localparam logic [1:0] SCSE_CKS_OUT = 2'h1;
	// counts
	localparam logic [3:0] SCSE_OS_LAST = 4'hf;
	localparam logic [3:0] SCSE_OS_MID = 4'h7;
	localparam logic [2:0] SCSE_SCK_HALF = 3'h7;
	localparam logic [3:0] SCSE_CNT_ONE = 4'h1;
	localparam logic [3:0] SCSE_TX_CNT_SYNC = 4'h9;
	localparam logic [3:0] SCSE_TX_CNT_ASYNC = 4'ha;
	localparam logic [3:0] SCSE_TX_CNT_PAR = 4'hb;
	localparam logic [3:0] SCSE_RX_LAST_SYNC = 4'h7;
	localparam logic [3:0] SCSE_RX_LAST = 4'h8;
	localparam logic [3:0] SCSE_RX_LAST_PAR = 4'h9;

	typedef enum logic [2:0] {
		SCSE_RX_IDLE = 3'b001,
		SCSE_RX_START = 3'b010,
		SCSE_RX_DATA = 3'b100
	} scse_rx_type;
endpackage

// File: src/scse_baud_div.sv
// divider that makes the sixteen-times bit-rate enable pulse
`timescale 1ns/100ps
`default_nettype none
module scse_baud_div
	import scse_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// control
	input wire logic en_i,
	input wire logic [WIDTH-1:0] div_i,
	// one-cycle pulse every div_i+1 cycles
	output logic tick_o
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic tick;
	} scse_div_type;

	scse_div_type q, d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!en_i) begin
			d.cnt = '0;
		end else if (q.cnt >= div_i) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_o = q.tick;
endmodule
`default_nettype wire

// File: src/scse_ctrl.sv
// serial control: clock source select, enables, flags and interrupt requests
// Summary of operation
// - async 00: baud generator, pin released
// - async 01: baud generator, bit clock out
// - async 1X: pin clock, sixteen times rate
// - sync 0X: internal clock driven on pin
// - sync 1X: pin is bit clock input
// - smart card select changes control meanings
// - transmit request only while enable bit 7
// - transmit request drops on flag clear
// - receive requests only while enable bit 6
// - receive requests drop on flag clear
// - transmit starts after data written, flag cleared
// - transmit off holds buffer-empty flag high
// - receive starts on start bit or clock
// - receive off keeps receive flags
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module scse_ctrl
	import scse_pkg::*;
#(
	parameter int DIV_WIDTH = 8
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_B_I,
	// register port
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	// serial pins
	input wire logic RXD_I,
	output logic TXD_O,
	input wire logic SCK_I,
	output logic SCK_O,
	output logic SCK_OE_B_O,
	// interrupt requests
	output logic TX_DATA_IRQ_O,
	output logic RX_DATA_IRQ_O,
	output logic RX_ERROR_IRQ_O,
	output logic IRQ_O
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] scmode;
		logic [7:0] baud;
		logic [7:0] tx_data;
		logic [7:0] rdr;
		logic [7:0] rdata;
		logic [4:0] flags;
		logic [4:0] arm;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic rxd_m;
		logic rxd_s;
		logic sck_m;
		logic sck_s;
		logic sck_prev;
		logic sck;
		logic [2:0] sck_div;
		logic tx_busy;
		logic [10:0] tx_sh;
		logic [3:0] tx_cnt;
		logic [3:0] tx_os;
		scse_rx_type rx_st;
		logic [9:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [3:0] rx_os;
	} scse_state_type;

	localparam scse_state_type ST_RST = '{
		ctrl: SCSE_CTRL_RST,
		baud: SCSE_BAUD_RST,
		flags: SCSE_FLAGS_RST,
		rxd_m: 1'b1,
		rxd_s: 1'b1,
		// pin rests high: a low start here would fake a rising edge
		sck_m: 1'b1,
		sck_s: 1'b1,
		sck_prev: 1'b1,
		sck: 1'b1,
		tx_sh: '1,
		rx_st: SCSE_RX_IDLE,
		default: '0
	};

	scse_state_type q, d;
	logic div_tick, div_en, os_tick, rise, fall;
	logic sm, sync_m, ext, sck_run, drive, tx_step;
	logic tx_ev, rx_done, rx_err, rx_complete, par_bit;
	logic [1:0] cks;
	logic [9:0] rx_new;
	logic [7:0] rx_data;

	scse_baud_div #(
		.WIDTH(DIV_WIDTH)
	) scse_baud_div_i (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.en_i(div_en),
		.div_i(q.baud[DIV_WIDTH-1:0]),
		.tick_o(div_tick)
	);

	always_comb begin
		d = q;
		d.rdata = 8'h00;
		tx_ev = 1'b0;
		rx_done = 1'b0;
		rx_err = 1'b0;
		rx_complete = 1'b0;
		tx_step = 1'b0;
		rx_data = 8'h00;
		d.rxd_m = RXD_I;
		d.rxd_s = q.rxd_m;
		d.sck_m = SCK_I;
		d.sck_s = q.sck_m;
		d.sck_prev = q.sck_s;
		// smart card mode has no external clock and no synchronous mode
		sm = q.scmode[SCSE_M_SMART_CARD_SELECT];
		sync_m = q.mode[SCSE_M_SYNC] & ~sm;
		cks = {q.ctrl[SCSE_B_CLOCK_SELECT_HI], q.ctrl[SCSE_B_CLOCK_SELECT_LO]};
		ext = cks[1] & ~sm;
		div_en = ~ext;
		os_tick = ext ? (q.sck_s & ~q.sck_prev) : div_tick;
		// master clock runs whenever a synchronous transfer may be under way
		if (sync_m) begin
			sck_run = ~ext & (q.tx_busy | q.ctrl[SCSE_B_RX_ON]);
			drive = ~cks[1];
		end else begin
			sck_run = (cks == SCSE_CKS_OUT);
			drive = sck_run;
		end
		if (!sck_run) begin
			d.sck_div = 3'h0;
			d.sck = 1'b1;
		end else if (div_tick) begin
			d.sck_div = q.sck_div + 3'h1;
			if (q.sck_div == SCSE_SCK_HALF) begin
				d.sck = ~q.sck;
			end
		end
		if (ext) begin
			rise = q.sck_s & ~q.sck_prev;
			fall = ~q.sck_s & q.sck_prev;
		end else begin
			rise = sck_run & div_tick & (q.sck_div == SCSE_SCK_HALF) & ~q.sck;
			fall = sck_run & div_tick & (q.sck_div == SCSE_SCK_HALF) & q.sck;
		end
		// register reads
		if (RD_I) begin
			unique case (ADDR_I)
				SCSE_A_CTRL: d.rdata = q.ctrl;
				SCSE_A_MODE: d.rdata = q.mode;
				SCSE_A_STAT: begin
					d.rdata = {q.flags, 3'h0};
					d.arm = q.arm | q.flags;
				end
				SCSE_A_TXD: d.rdata = q.tx_data;
				SCSE_A_SCMODE: d.rdata = q.scmode;
				SCSE_A_RXD: d.rdata = q.rdr;
				SCSE_A_IRQ_STAT: begin
					d.rdata = {5'h00, q.irq_stat};
					d.irq_stat = 3'h0;
				end
				SCSE_A_IRQ_MASK: d.rdata = {5'h00, q.irq_mask};
				SCSE_A_BAUD: d.rdata = q.baud;
				default: d.rdata = 8'h00;
			endcase
		end
		// register writes; flags clear only after being read as 1
		if (WR_I) begin
			unique case (ADDR_I)
				SCSE_A_CTRL: d.ctrl = WDATA_I;
				SCSE_A_MODE: d.mode = WDATA_I;
				SCSE_A_STAT: d.flags = q.flags &
					~(q.arm & ~WDATA_I[7:SCSE_STAT_LSB]);
				SCSE_A_TXD: d.tx_data = WDATA_I;
				SCSE_A_SCMODE: d.scmode = WDATA_I;
				SCSE_A_IRQ_MASK: d.irq_mask = WDATA_I[2:0];
				SCSE_A_BAUD: d.baud = WDATA_I;
				default: d.ctrl = q.ctrl;
			endcase
		end
		// transmitter
		par_bit = (^q.tx_data) ^ q.mode[SCSE_M_PAR_ODD];
		if (!q.ctrl[SCSE_B_TX_ON]) begin
			d.flags[SCSE_F_TX_BUFFER_EMPTY] = 1'b1;
			d.tx_busy = 1'b0;
			d.tx_sh = '1;
		end else if (!q.tx_busy) begin
			if (!q.flags[SCSE_F_TX_BUFFER_EMPTY]) begin
				d.tx_busy = 1'b1;
				d.flags[SCSE_F_TX_BUFFER_EMPTY] = 1'b1;
				tx_ev = 1'b1;
				d.tx_os = 4'h0;
				if (sync_m) begin
					d.tx_sh = {2'b11, q.tx_data, 1'b1};
					d.tx_cnt = SCSE_TX_CNT_SYNC;
				end else if (q.mode[SCSE_M_PAR_ON]) begin
					d.tx_sh = {1'b1, par_bit, q.tx_data, 1'b0};
					d.tx_cnt = SCSE_TX_CNT_PAR;
				end else begin
					d.tx_sh = {2'b11, q.tx_data, 1'b0};
					d.tx_cnt = SCSE_TX_CNT_ASYNC;
				end
			end
		end else begin
			tx_step = sync_m ? fall : (os_tick & (q.tx_os == SCSE_OS_LAST));
			if (!sync_m && os_tick) begin
				d.tx_os = q.tx_os + 4'h1;
			end
			if (tx_step) begin
				if (q.tx_cnt == SCSE_CNT_ONE) begin
					d.tx_busy = 1'b0;
					d.tx_sh = '1;
				end else begin
					d.tx_sh = {1'b1, q.tx_sh[10:1]};
					d.tx_cnt = q.tx_cnt - 4'h1;
				end
			end
		end
		// receiver
		rx_new = {q.rxd_s, q.rx_sh[9:1]};
		if (!q.ctrl[SCSE_B_RX_ON]) begin
			d.rx_st = SCSE_RX_IDLE;
			d.rx_cnt = 4'h0;
		end else if (sync_m) begin
			if (rise) begin
				d.rx_sh = rx_new;
				d.rx_cnt = q.rx_cnt + 4'h1;
				if (q.rx_cnt == SCSE_RX_LAST_SYNC) begin
					d.rx_cnt = 4'h0;
					rx_complete = 1'b1;
					rx_data = rx_new[9:2];
				end
			end
		end else begin
			unique case (q.rx_st)
				SCSE_RX_IDLE: begin
					if (os_tick && !q.rxd_s) begin
						d.rx_st = SCSE_RX_START;
						d.rx_os = 4'h0;
					end
				end
				SCSE_RX_START: begin
					if (os_tick) begin
						d.rx_os = q.rx_os + 4'h1;
						if (q.rx_os == SCSE_OS_MID) begin
							d.rx_os = 4'h0;
							d.rx_cnt = 4'h0;
							// a short glitch is not a start bit
							d.rx_st = q.rxd_s ? SCSE_RX_IDLE : SCSE_RX_DATA;
						end
					end
				end
				SCSE_RX_DATA: begin
					if (os_tick) begin
						d.rx_os = q.rx_os + 4'h1;
						if (q.rx_os == SCSE_OS_LAST) begin
							d.rx_sh = rx_new;
							d.rx_cnt = q.rx_cnt + 4'h1;
							if (q.rx_cnt == (q.mode[SCSE_M_PAR_ON] ?
								SCSE_RX_LAST_PAR : SCSE_RX_LAST)) begin
								d.rx_st = SCSE_RX_IDLE;
								rx_complete = 1'b1;
								rx_data = q.mode[SCSE_M_PAR_ON] ?
									rx_new[7:0] : rx_new[8:1];
							end
						end
					end
				end
				default: d.rx_st = SCSE_RX_IDLE;
			endcase
		end
		// completion: a full buffer is kept and the new byte is lost
		if (rx_complete) begin
			if (q.flags[SCSE_F_RX_BUFFER_FULL]) begin
				d.flags[SCSE_F_OVERRUN_ERROR] = 1'b1;
				rx_err = 1'b1;
			end else begin
				d.rdr = rx_data;
				d.flags[SCSE_F_RX_BUFFER_FULL] = 1'b1;
				rx_done = 1'b1;
				if (!sync_m) begin
					d.flags[SCSE_F_FRAMING_ERROR] = ~rx_new[9];
					d.flags[SCSE_F_PARITY_ERROR] =
						q.mode[SCSE_M_PAR_ON] & (rx_new[8] !=
						((^rx_new[7:0]) ^ q.mode[SCSE_M_PAR_ODD]));
					rx_err = ~rx_new[9] | d.flags[SCSE_F_PARITY_ERROR];
				end
			end
		end
		// hardware set wins over a clear in the same cycle
		d.irq_stat[SCSE_E_TX] = d.irq_stat[SCSE_E_TX] | tx_ev;
		d.irq_stat[SCSE_E_RX] = d.irq_stat[SCSE_E_RX] | rx_done;
		d.irq_stat[SCSE_E_ERR] = d.irq_stat[SCSE_E_ERR] | rx_err;
		d.arm = d.arm & d.flags;
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	assign RDATA_O = q.rdata;
	assign TXD_O = q.tx_sh[0];
	assign SCK_O = q.sck;
	assign SCK_OE_B_O = ~drive;
	assign TX_DATA_IRQ_O = q.flags[SCSE_F_TX_BUFFER_EMPTY] &
		q.ctrl[SCSE_B_TX_IRQ_ON];
	assign RX_DATA_IRQ_O = q.flags[SCSE_F_RX_BUFFER_FULL] &
		q.ctrl[SCSE_B_RX_IRQ_ON];
	assign RX_ERROR_IRQ_O = |q.flags[SCSE_F_OVERRUN_ERROR:0] &
		q.ctrl[SCSE_B_RX_IRQ_ON];
	assign IRQ_O = |(q.irq_stat & q.irq_mask);

	pin_release_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(!q.mode[SCSE_M_SYNC] && cks == 2'h0) |-> SCK_OE_B_O)
		else $error("clock pin driven in released setting");
	// a register write may change the setting under the next edge
	async_clk_out_a: assert property (@(posedge CLK_I)
		disable iff (!RST_B_I)
		(!WR_I && !sync_m && cks == SCSE_CKS_OUT && div_tick &&
		q.sck_div == SCSE_SCK_HALF) |=>
		(!SCK_OE_B_O && SCK_O != $past(SCK_O)))
		else $error("bit clock not toggled on pin");
	ext_clk_in_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(cks[1] && !sm) |-> (SCK_OE_B_O && !div_en))
		else $error("external clock setting drives pin");
	sync_out_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(sync_m && !cks[1]) |-> !SCK_OE_B_O)
		else $error("sync internal clock not driven");
	tx_req_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		$rose(TX_DATA_IRQ_O) |-> q.ctrl[SCSE_B_TX_IRQ_ON] &&
		q.flags[SCSE_F_TX_BUFFER_EMPTY])
		else $error("transmit request without enable");
	rx_req_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(RX_DATA_IRQ_O || RX_ERROR_IRQ_O) |-> q.ctrl[SCSE_B_RX_IRQ_ON])
		else $error("receive request without enable");
	empty_clear_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(WR_I && ADDR_I == SCSE_A_STAT && q.ctrl[SCSE_B_TX_ON] &&
		q.arm[SCSE_F_TX_BUFFER_EMPTY] &&
		!WDATA_I[SCSE_STAT_LSB + SCSE_F_TX_BUFFER_EMPTY]) |=>
		(!q.flags[SCSE_F_TX_BUFFER_EMPTY] && !TX_DATA_IRQ_O))
		else $error("armed clear of empty flag ignored");
	tx_start_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(!WR_I && q.ctrl[SCSE_B_TX_ON] &&
		!q.flags[SCSE_F_TX_BUFFER_EMPTY] && !q.tx_busy) |=>
		(q.tx_busy && q.flags[SCSE_F_TX_BUFFER_EMPTY] && TXD_O == sync_m))
		else $error("transmission did not start");
	tx_off_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		!q.ctrl[SCSE_B_TX_ON] |=>
		(q.flags[SCSE_F_TX_BUFFER_EMPTY] && !q.tx_busy && TXD_O))
		else $error("empty flag not held while transmit off");
	start_bit_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(q.ctrl[SCSE_B_RX_ON] && !sync_m && q.rx_st == SCSE_RX_IDLE &&
		os_tick && !q.rxd_s) |=> q.rx_st == SCSE_RX_START)
		else $error("start bit not taken");
	rx_flags_keep_a: assert property (@(posedge CLK_I)
		disable iff (!RST_B_I)
		(!q.ctrl[SCSE_B_RX_ON] && !(WR_I && ADDR_I == SCSE_A_STAT)) |=>
		$stable(q.flags[SCSE_F_RX_BUFFER_FULL:0]))
		else $error("receive flags changed while receive off");
endmodule
`default_nettype wire

// File: test/scse_partner.sv
// remote serial partner: async sender and receiver at sixteen clocks a bit
`timescale 1ns/100ps
`default_nettype none
module scse_partner (
	// clock
	input wire logic clk_i,
	// serial pins
	input wire logic txd_i,
	output logic rxd_o,
	output logic sck_o
);
	localparam int BIT = 16;
	initial begin
		rxd_o = 1'b1;
		// no external clock offered: the pulled-up pin rests high
		sck_o = 1'b1;
	end
	task automatic send(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o <= f[i];
			repeat (BIT) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask
	// outside clock source: sixteen pulses a bit, four cycles each
	task automatic send_ext(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o <= f[i];
			repeat (BIT) begin
				sck_o <= 1'b0;
				repeat (2) @(posedge clk_i);
				sck_o <= 1'b1;
				repeat (2) @(posedge clk_i);
			end
		end
		rxd_o <= 1'b1;
	endtask
	task automatic recv(output logic [7:0] d);
		@(negedge txd_i);
		// sample mid bit so a one-cycle skew does not matter
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_i);
			d[i] = txd_i;
		end
	endtask
endmodule
`default_nettype wire

// File: test/test_serial_clock_select_and_enables.sv
// self-checking bench for the serial control block
`timescale 1ns/100ps
`default_nettype none
module test_serial_clock_select_and_enables
	import scse_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic rxd, txd, sck_in, sck_out, sck_oe_b, sck_ext;
	logic tx_irq, rx_irq, err_irq, irq;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	// pin level: partner side while the block lets go
	assign sck_in = sck_oe_b ? sck_ext : sck_out;
	scse_ctrl #(.DIV_WIDTH(8)) scse_ctrl_i (.CLK_I(clk), .RST_B_I(rst_b),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .RXD_I(rxd), .TXD_O(txd), .SCK_I(sck_in),
		.SCK_O(sck_out), .SCK_OE_B_O(sck_oe_b), .TX_DATA_IRQ_O(tx_irq),
		.RX_DATA_IRQ_O(rx_irq), .RX_ERROR_IRQ_O(err_irq), .IRQ_O(irq));
	scse_partner scse_partner_i (.clk_i(clk), .txd_i(txd), .rxd_o(rxd),
		.sck_o(sck_ext));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rreg(a, d);
		chk(d, e);
	endtask
	task automatic t_reset();
		chk({4'h0, tx_irq, rx_irq, err_irq, irq}, 8'h00);
		chk({6'h00, sck_oe_b, txd}, 8'h03);
		rchk(SCSE_A_CTRL, SCSE_CTRL_RST);
		rchk(SCSE_A_STAT, 8'h80);
		// unmapped index swallows writes and reads back zero
		wreg(4'hf, 8'hff);
		rchk(4'hf, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_clock();
		logic [4:0] tbl [7];
		logic [7:0] n;
		logic prev;
		// rows: expected active-low output enable, card select, sync, clock select
		tbl = '{5'h10, 5'h01, 5'h12, 5'h04, 5'h16, 5'h1c, 5'h1a};
		wreg(SCSE_A_BAUD, 8'h00);
		for (int i = 0; i < 7; i++) begin
			wreg(SCSE_A_SCMODE, {7'h00, tbl[i][3]});
			wreg(SCSE_A_MODE, {7'h00, tbl[i][2]});
			wreg(SCSE_A_CTRL, {6'h00, tbl[i][1:0]});
			#1 chk({7'h00, sck_oe_b}, {7'h00, tbl[i][4]});
		end
		wreg(SCSE_A_SCMODE, 8'h00);
		wreg(SCSE_A_MODE, 8'h00);
		wreg(SCSE_A_CTRL, {6'h00, SCSE_CKS_OUT});
		repeat (16) @(posedge clk);
		#1 prev = sck_out;
		n = 8'h00;
		repeat (64) begin
			@(posedge clk);
			#1 if (sck_out !== prev) n++;
			prev = sck_out;
		end
		chk(n, 8'h08);
		wreg(SCSE_A_CTRL, 8'h00);
		$display("test clock select done");
	endtask
	task automatic t_tx();
		logic [7:0] got;
		logic [7:0] d;
		wreg(SCSE_A_MODE, 8'h00);
		wreg(SCSE_A_CTRL, 8'ha0);
		#1 chk({7'h00, tx_irq}, 8'h01);
		wreg(SCSE_A_TXD, 8'ha5);
		rreg(SCSE_A_STAT, d);
		fork
			scse_partner_i.recv(got);
			begin
				wreg(SCSE_A_STAT, 8'h7f);
				#1 chk({7'h00, tx_irq}, 8'h00);
			end
		join
		chk(got, 8'ha5);
		repeat (32) @(posedge clk);
		// transmitter off: clearing the empty flag must not stick
		wreg(SCSE_A_CTRL, 8'h80);
		wreg(SCSE_A_TXD, 8'h11);
		rreg(SCSE_A_STAT, d);
		wreg(SCSE_A_STAT, 8'h7f);
		rchk(SCSE_A_STAT, 8'h80);
		chk({7'h00, tx_irq}, 8'h01);
		wreg(SCSE_A_CTRL, 8'h00);
		#1 chk({7'h00, tx_irq}, 8'h00);
		$display("test transmit done");
	endtask
	task automatic t_rx();
		logic [7:0] d;
		rreg(SCSE_A_IRQ_STAT, d);
		wreg(SCSE_A_IRQ_MASK, 8'h02);
		wreg(SCSE_A_MODE, 8'h00);
		wreg(SCSE_A_CTRL, 8'h50);
		scse_partner_i.send(8'h3c, 1'b1);
		for (int i = 0; i < 40 && rx_irq !== 1'b1; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		#1 chk({6'h00, rx_irq, irq}, 8'h03);
		rchk(SCSE_A_RXD, 8'h3c);
		wreg(SCSE_A_CTRL, 8'h40);
		rchk(SCSE_A_STAT, 8'hc0);
		wreg(SCSE_A_STAT, 8'hbf);
		#1 chk({7'h00, rx_irq}, 8'h00);
		rchk(SCSE_A_IRQ_STAT, 8'h02);
		@(posedge clk);
		#1 chk({7'h00, irq}, 8'h00);
		// a low stop bit raises the error request
		wreg(SCSE_A_CTRL, 8'h50);
		scse_partner_i.send(8'h5a, 1'b0);
		repeat (8) @(posedge clk);
		#1 chk({7'h00, err_irq}, 8'h01);
		wreg(SCSE_A_CTRL, 8'h10);
		#1 chk({6'h00, rx_irq, err_irq}, 8'h00);
		$display("test receive done");
	endtask
	task automatic t_ext();
		logic [7:0] d;
		// drop the flags left by the previous frames first
		rreg(SCSE_A_STAT, d);
		wreg(SCSE_A_STAT, 8'h80);
		rchk(SCSE_A_STAT, 8'h80);
		wreg(SCSE_A_CTRL, 8'h52);
		scse_partner_i.send_ext(8'hc3);
		repeat (4) @(posedge clk);
		#1 chk({6'h00, rx_irq, err_irq}, 8'h02);
		rchk(SCSE_A_RXD, 8'hc3);
		wreg(SCSE_A_CTRL, 8'h00);
		$display("test external clock done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_clock();
		t_tx();
		t_rx();
		t_ext();
		results();
	end
endmodule
`default_nettype wire
